// ==== src/ext_bus_ctrl.sv ====
// external bus master: address, data, selects, strobes, wait and bus hand-over
// Summary of operation
// - address lines 23..0 are driven outputs carrying each external access address.
// - data lines 15..0 are driven on writes and sampled on reads.
// - one active-low select per area 7..0, the accessed area's select goes low.
// - address strobe goes low while a valid address is presented.
// - read strobe goes low during an external read.
// - upper byte write strobe goes low on a write only when data 15..8 is valid.
// - lower byte write strobe goes low on a write only when data 7..0 is valid.
// - a low stall input inserts wait states into external bus cycles.
// - bus grant output goes low while the bus is released to the outside master.
module ext_bus_ctrl #(
    parameter int ADDR_W = ext_bus_pkg::ADDR_W,
    parameter int DATA_W = ext_bus_pkg::DATA_W,
    parameter int AREA_N = ext_bus_pkg::AREA_N
) (
    input  wire logic              clk_sys_in,          // system clock
    input  wire logic              sys_rst_in,          // async reset, active high
    input  wire logic              req_valid_in,        // internal access request
    input  wire logic              req_write_in,        // 1 write, 0 read
    input  wire logic [ADDR_W-1:0] req_addr_in,         // access address
    input  wire logic [DATA_W-1:0] req_wdata_in,        // write data
    input  wire logic [1:0]        req_be_in,           // byte enables: [1] upper, [0] lower
    output logic                   req_ready_out,       // request taken on the previous edge
    output logic                   rsp_valid_out,       // access finished pulse
    output logic [DATA_W-1:0]      rsp_rdata_out,       // read data
    output logic [ADDR_W-1:0]      addr_out,            // address lines
    input  wire logic [DATA_W-1:0] data_in,             // data lines, sampled
    output logic [DATA_W-1:0]      data_out,            // data lines, driven
    output logic                   data_oe_out,         // data lines driven when high
    output logic [AREA_N-1:0]      area_sel_n_out,      // area selects, active low
    output logic                   address_strobe_n_out, // address valid, active low
    output logic                   read_strobe_n_out,   // read strobe, active low
    output logic                   upper_byte_write_n_out, // upper byte write, active low
    output logic                   lower_byte_write_n_out, // lower byte write, active low
    input  wire logic              stall_n_in,          // wait request, active low
    input  wire logic              bus_claim_n_in,      // outside master request, active low
    output logic                   bus_grant_n_out      // bus released, active low
);
    localparam int AREA_W = $clog2(AREA_N);

    ext_bus_pkg::bus_state_t state;      // where the bus cycle stands
    logic                    wr_q;       // captured direction
    logic [1:0]              be_q;       // captured byte lanes
    logic [AREA_W-1:0]       area_idx;   // area of the offered address
    logic [AREA_N-1:0]       next_sel_n; // decoded selects for the offered address
    logic                    take_req;   // request accepted on this edge
    logic                    data_end;   // data phase closes on this edge
    logic                    bus_idle;   // between accesses, bus still ours
    logic                    bus_away;   // bus handed to the outside master
    logic                    claim;      // outside master asks for the bus

    // area index taken from the top address bits
    assign area_idx = req_addr_in[ext_bus_pkg::AREA_LSB +: AREA_W];

    // claim turned active high once, used everywhere below
    assign claim = ~bus_claim_n_in;

    // a claim wins over a pending request, so no cycle starts under a hand-over
    assign bus_idle = (state == ext_bus_pkg::ST_IDLE);
    assign bus_away = (state == ext_bus_pkg::ST_GRANT);
    assign take_req = bus_idle && !claim && req_valid_in;

    // a low stall input keeps the data phase open
    assign data_end = (state == ext_bus_pkg::ST_DATA) && stall_n_in;

    // one comparator per area; only the matching area's select goes low
    generate
        for (genvar g = 0; g < AREA_N; g++) begin : gen_sel
            assign next_sel_n[g] = (area_idx != AREA_W'(g));
        end
    endgenerate

    // bus cycle sequencer; a claim is honoured only between accesses so no cycle is torn
    // limitation: a claim raised mid-access waits for the recovery cycle to end
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state <= ext_bus_pkg::ST_IDLE;
        end else begin
            case (state)
                ext_bus_pkg::ST_IDLE: begin
                    if (claim) begin
                        state <= ext_bus_pkg::ST_GRANT;
                    end else if (req_valid_in) begin
                        state <= ext_bus_pkg::ST_ADDR;
                    end
                end
                // address setup: selects and address strobe already out
                ext_bus_pkg::ST_ADDR: begin
                    state <= ext_bus_pkg::ST_DATA;
                end
                // strobes out; stay while the far side stalls
                ext_bus_pkg::ST_DATA: begin
                    if (stall_n_in) begin
                        state <= ext_bus_pkg::ST_DONE;
                    end else begin
                        state <= ext_bus_pkg::ST_DATA;
                    end
                end
                // recovery cycle: address strobe and selects go back high
                ext_bus_pkg::ST_DONE: begin
                    state <= ext_bus_pkg::ST_IDLE;
                end
                // bus handed away until the claim is dropped
                ext_bus_pkg::ST_GRANT: begin
                    if (!claim) begin
                        state <= ext_bus_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= ext_bus_pkg::ST_IDLE;                        // unused codes recover
                end
            endcase
        end
    end

    // request capture: address, data, direction, byte lanes
    // address and data hold after the access, so the lines do not flutter between cycles
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            addr_out <= ext_bus_pkg::ADDR_RST;
            data_out <= ext_bus_pkg::DATA_RST;
            wr_q     <= 1'b0;
            be_q     <= 2'b00;
        end else if (take_req) begin
            addr_out <= req_addr_in;
            data_out <= req_wdata_in;
            wr_q     <= req_write_in;
            be_q     <= req_be_in;
        end
    end

    // selects cover the whole access, address setup included
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            area_sel_n_out <= ext_bus_pkg::SEL_IDLE;
        end else if (take_req) begin
            area_sel_n_out <= next_sel_n;
        end else if (state == ext_bus_pkg::ST_DONE || bus_away) begin
            area_sel_n_out <= ext_bus_pkg::SEL_IDLE;
        end
    end

    // address strobe low from the accepting edge to the recovery edge
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            address_strobe_n_out <= 1'b1;
        end else if (take_req) begin
            address_strobe_n_out <= 1'b0;
        end else if (state == ext_bus_pkg::ST_DONE || bus_away) begin
            address_strobe_n_out <= 1'b1;
        end
    end

    // read strobe opens one cycle after the address and stays through waits
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            read_strobe_n_out <= 1'b1;
        end else if (state == ext_bus_pkg::ST_ADDR) begin
            read_strobe_n_out <= wr_q;
        end else if (data_end) begin
            read_strobe_n_out <= 1'b1;
        end
    end

    // write strobes per lane; a lane without its byte enable stays high, so an empty mask writes nothing
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            upper_byte_write_n_out <= 1'b1;
            lower_byte_write_n_out <= 1'b1;
        end else if (state == ext_bus_pkg::ST_ADDR) begin
            upper_byte_write_n_out <= ~(wr_q & be_q[1]);
            lower_byte_write_n_out <= ~(wr_q & be_q[0]);
        end else if (data_end) begin
            upper_byte_write_n_out <= 1'b1;
            lower_byte_write_n_out <= 1'b1;
        end
    end

    // data drive kept one cycle past the strobes so the data holds over the write edge
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            data_oe_out <= 1'b0;
        end else if (state == ext_bus_pkg::ST_ADDR) begin
            data_oe_out <= wr_q;
        end else if (state != ext_bus_pkg::ST_DATA) begin
            data_oe_out <= 1'b0;
        end
    end

    // read data taken on the edge that closes the data phase, held until the next read
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rsp_rdata_out <= ext_bus_pkg::DATA_RST;
        end else if (data_end && !wr_q) begin
            rsp_rdata_out <= data_in;
        end
    end

    // handshake pulses, one cycle each
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
        end else begin
            req_ready_out <= take_req;
            rsp_valid_out <= data_end;
        end
    end

    // grant low on the edge after a claim is seen idle, and as long as the claim lasts
    // a claim seen mid-access is answered only once the sequencer is back idle
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_grant_n_out <= 1'b1;
        end else if (claim && (bus_idle || bus_away)) begin
            bus_grant_n_out <= 1'b0;
        end else begin
            bus_grant_n_out <= 1'b1;
        end
    end
endmodule : ext_bus_ctrl

// ==== src/ext_bus_pkg.sv ====
// constants shared by the external bus controller
package ext_bus_pkg;
    localparam int ADDR_W      = 24;   // address lines 23..0
    localparam int DATA_W      = 16;   // data lines 15..0
    localparam int AREA_N      = 8;    // select areas 7..0
    localparam int AREA_LSB    = 21;   // area index taken from top address bits
    localparam int SETUP_CYC   = 1;    // address setup before strobes
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam logic [AREA_N-1:0] SEL_IDLE = 8'hff;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_DATA  = 3'b010,
        ST_DONE  = 3'b011,
        ST_GRANT = 3'b100
    } bus_state_t;
endpackage : ext_bus_pkg

// ==== sim/ext_bus_mem.sv ====
// external memory model: one word per area, answers on the read strobe
module ext_bus_mem (
    input  wire logic [2:0]  area_in, // area bits of the address
    input  wire logic        clk_in,  // system clock
    input  wire logic [15:0] bus_in,  // resolved data lines
    input  wire logic        rd_n_in, // read strobe
    input  wire logic [1:0]  wr_n_in, // upper, lower write strobes
    output logic      [15:0] bus_out  // data driven back
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [8];
    // lanes stored apart, each only under its own strobe
    always @(posedge clk_in) begin
        if (!wr_n_in[1]) mem[area_in][15:8] <= bus_in[15:8];
        if (!wr_n_in[0]) mem[area_in][7:0] <= bus_in[7:0];
    end
    // released bus shows the inverse word, so a sample outside the strobe cannot match by luck
    assign bus_out = !rd_n_in ? mem[area_in] : ~mem[area_in];
endmodule : ext_bus_mem

// ==== sim/ext_bus_ctrl_assertions.sv ====
// pin checks for the external bus controller
module ext_bus_ctrl_assertions (
    input wire logic        clk_sys_in, sys_rst_in, req_ready_out, rsp_valid_out, data_oe_out, // handshake
    input wire logic [23:0] addr_out,        // address lines
    input wire logic [7:0]  area_sel_n_out,  // area selects
    input wire logic        address_strobe_n_out, read_strobe_n_out, upper_byte_write_n_out, // strobes
    input wire logic        lower_byte_write_n_out, stall_n_in, bus_claim_n_in, bus_grant_n_out // strobe, wait, claim
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);
    sel_decode_a: assert property (!address_strobe_n_out |-> area_sel_n_out == ~(8'h01 << addr_out[23:21]))
        else $error("select does not match address area");
    ready_addr_a: assert property (req_ready_out |-> !address_strobe_n_out && read_strobe_n_out)
        else $error("address phase missing at acceptance");
    read_phase_a: assert property (!read_strobe_n_out |-> !address_strobe_n_out && upper_byte_write_n_out)
        else $error("read strobe outside a bus cycle");
    write_drive_a: assert property (!(upper_byte_write_n_out && lower_byte_write_n_out) |-> data_oe_out)
        else $error("write strobe without driven data");
    stall_hold_a: assert property (!stall_n_in && !read_strobe_n_out |=> !read_strobe_n_out && !rsp_valid_out)
        else $error("wait request ignored");
    done_idle_a: assert property (rsp_valid_out |-> read_strobe_n_out ##1 area_sel_n_out == 8'hff)
        else $error("strobes not released after access");
    grant_cause_a: assert property (!bus_grant_n_out |-> !$past(bus_claim_n_in))
        else $error("grant without claim");
    grant_quiet_a: assert property (!bus_grant_n_out |-> address_strobe_n_out && area_sel_n_out == 8'hff)
        else $error("bus active while granted away");
endmodule : ext_bus_ctrl_assertions
bind ext_bus_ctrl ext_bus_ctrl_assertions chk (.*);

// ==== sim/ext_bus_ctrl_tb.sv ====
// self-checking bench for the external bus controller
module ext_bus_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 0, sys_rst_in = 1, req_valid_in = 0, req_write_in = 0, stall_n_in = 1, bus_claim_n_in = 1;
    logic req_ready_out, rsp_valid_out, data_oe_out, address_strobe_n_out, read_strobe_n_out, bus_grant_n_out;
    logic upper_byte_write_n_out, lower_byte_write_n_out;
    logic [23:0] req_addr_in = 24'h0, addr_out;
    logic [15:0] req_wdata_in = 16'h0, data_out, mem_out, rsp_rdata_out;
    logic [1:0]  req_be_in = 2'h0;
    logic [7:0]  area_sel_n_out;
    wire  [15:0] data_in = data_oe_out ? data_out : mem_out;
    int          n_fail = 0, checks_done = 0, cyc = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    ext_bus_ctrl dut (.clk_sys_in, .sys_rst_in, .req_valid_in, .req_write_in, .req_addr_in, .req_wdata_in,
        .req_be_in, .req_ready_out, .rsp_valid_out, .rsp_rdata_out, .addr_out, .data_in, .data_out, .data_oe_out,
        .area_sel_n_out, .address_strobe_n_out, .read_strobe_n_out, .upper_byte_write_n_out,
        .lower_byte_write_n_out, .stall_n_in, .bus_claim_n_in, .bus_grant_n_out);
    ext_bus_mem mem (.area_in(addr_out[23:21]), .clk_in(clk_sys_in), .bus_in(data_in), .rd_n_in(read_strobe_n_out),
        .wr_n_in({upper_byte_write_n_out, lower_byte_write_n_out}), .bus_out(mem_out));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one access; nst cycles of wait request, e is the expected read word
    task automatic access(input logic wr, input logic [23:0] a, input logic [15:0] d, input logic [1:0] be,
                          input int nst, input logic [15:0] e);
        int t;
        @(negedge clk_sys_in);
        {req_valid_in, req_write_in, req_addr_in, req_wdata_in, req_be_in} = {1'b1, wr, a, d, be};
        for (t = 0; t < 20 && req_ready_out !== 1'b1; t++) @(negedge clk_sys_in);
        chk("address", a, addr_out);
        chk("select", {16'h0, ~(8'h01 << a[23:21])}, {16'h0, area_sel_n_out});
        req_valid_in = 0;
        stall_n_in = (nst == 0);
        for (t = 1; t < 30 && rsp_valid_out !== 1'b1; t++) begin
            @(negedge clk_sys_in);
            if (t == nst + 1) stall_n_in = 1; // stall counts from the data-phase edge on
        end
        chk("latency", 24'(3 + nst), 24'(t));
        if (!wr) chk("read data", {8'h0, e}, {8'h0, rsp_rdata_out});
    endtask : access
    task automatic t_areas;
        for (int i = 0; i < 8; i++) access(1, {3'(i), 21'h0abcd0}, 16'hc300 | 16'(i), 2'b11, 0, 0);
        for (int i = 0; i < 8; i++) access(0, {3'(i), 21'h0abcd0}, 0, 0, i % 4, 16'hc300 | 16'(i));
    endtask : t_areas
    // byte lanes written apart, and an empty lane mask writes nothing
    task automatic t_lanes;
        access(1, 24'h400010, 16'h1234, 2'b10, 0, 0);
        access(1, 24'h400010, 16'h5678, 2'b01, 2, 0);
        access(1, 24'h400010, 16'hffff, 2'b00, 0, 0);
        access(0, 24'h400010, 0, 0, 1, 16'h1278);
    endtask : t_lanes
    // request during grant must stay unanswered until the claim ends
    task automatic t_grant;
        @(negedge clk_sys_in);
        bus_claim_n_in = 0;
        repeat (2) @(negedge clk_sys_in);
        {req_valid_in, req_addr_in} = {1'b1, 24'h600040};
        repeat (4) begin
            @(negedge clk_sys_in);
            chk("refused", 24'h0, {23'h0, req_ready_out});
        end
        chk("held address", 24'h400010, addr_out);
        chk("grant", 24'h0, {23'h0, bus_grant_n_out});
        chk("idle pins", 24'h000fff, {12'h0, area_sel_n_out, address_strobe_n_out, read_strobe_n_out,
            upper_byte_write_n_out, lower_byte_write_n_out});
        {req_valid_in, bus_claim_n_in} = 2'b01;
        repeat (2) @(negedge clk_sys_in);
        chk("grant", 24'h1, {23'h0, bus_grant_n_out});
        access(0, 24'he00020, 0, 0, 0, 16'hc307);
    endtask : t_grant
    // reset in mid-write: every pin returns to idle at once and the torn write never lands
    task automatic t_reset;
        @(negedge clk_sys_in);
        {req_valid_in, req_write_in, req_addr_in} = {1'b1, 1'b1, 24'ha00040};
        {req_wdata_in, req_be_in} = {16'h0f0f, 2'b11};
        @(negedge clk_sys_in);
        chk("accept", 24'h1, {23'h0, req_ready_out & ~address_strobe_n_out});
        req_valid_in = 0;
        @(negedge clk_sys_in);
        chk("write lanes", 24'h040f0f,
            {5'h0, data_oe_out, upper_byte_write_n_out, lower_byte_write_n_out, data_out});
        sys_rst_in = 1;
        @(negedge clk_sys_in);
        chk("reset pins", 24'h000fff, {12'h0, area_sel_n_out, address_strobe_n_out, read_strobe_n_out,
            upper_byte_write_n_out, lower_byte_write_n_out});
        chk("reset flags", 24'h000008, {20'h0, bus_grant_n_out, data_oe_out, req_ready_out, rsp_valid_out});
        chk("reset lines", 24'h0, addr_out | {8'h0, data_out} | {8'h0, rsp_rdata_out});
        sys_rst_in = 0;
        access(0, 24'ha00040, 0, 0, 0, 16'hc305);
    endtask : t_reset
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    initial begin
        repeat (4) @(negedge clk_sys_in);
        sys_rst_in = 0;
        t_areas;
        t_lanes;
        t_grant;
        t_reset;
        end_sim;
    end
    // hang guard, well above the roughly 120 cycles used
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_sim;
        end
    end
endmodule : ext_bus_ctrl_tb
